// File: src/scia_axil_slave.v
// axi4-lite slave front end: turns bus transfers into one-cycle
// register write and read strobes for the indirect access port.
// assumes the register file decodes the address within the same cycle.
`timescale 1ns/1ns
`include "scia_map.vh"

module scia_axil_slave (
   input  wire                   aclk,
   input  wire                   aresetn,
   input  wire [`SCIA_AW-1:0]    s_axi_awaddr,
   input  wire                   s_axi_awvalid,
   output reg                    s_axi_awready,
   input  wire [31:0]            s_axi_wdata,
   input  wire [3:0]             s_axi_wstrb,
   input  wire                   s_axi_wvalid,
   output reg                    s_axi_wready,
   output reg  [1:0]             s_axi_bresp,
   output reg                    s_axi_bvalid,
   input  wire                   s_axi_bready,
   input  wire [`SCIA_AW-1:0]    s_axi_araddr,
   input  wire                   s_axi_arvalid,
   output reg                    s_axi_arready,
   output reg  [31:0]            s_axi_rdata,
   output reg  [1:0]             s_axi_rresp,
   output reg                    s_axi_rvalid,
   input  wire                   s_axi_rready,
   output reg                    wr_en,
   output reg  [`SCIA_AW-1:0]    wr_addr,
   output reg  [31:0]            wr_data,
   output reg  [3:0]             wr_strb,
   input  wire                   wr_ok,
   output reg                    rd_en,
   output reg  [`SCIA_AW-1:0]    rd_addr,
   input  wire [31:0]            rd_data,
   input  wire                   rd_ok
);

   // ********************************
   // write channel
   // ********************************
   // address and data are caught independently, so either may come first
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `SCIA_RESP_OKAY;
         wr_en         <= 1'b0;
         wr_addr       <= {`SCIA_AW{1'b0}};
         wr_data       <= `SCIA_WORD_ZERO;
         wr_strb       <= `SCIA_LANE_ZERO;
      end else begin
         wr_en <= 1'b0;
         if (s_axi_awvalid && s_axi_awready) begin
            wr_addr       <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wr_data      <= s_axi_wdata;
            wr_strb      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
            wr_en        <= 1'b1;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? `SCIA_RESP_OKAY : `SCIA_RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // ********************************
   // read channel
   // ********************************
   // rd_data is sampled in the strobe cycle, before any read side effect
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= `SCIA_WORD_ZERO;
         s_axi_rresp   <= `SCIA_RESP_OKAY;
         rd_en         <= 1'b0;
         rd_addr       <= {`SCIA_AW{1'b0}};
      end else begin
         rd_en <= 1'b0;
         if (s_axi_arvalid && s_axi_arready) begin
            rd_addr       <= s_axi_araddr;
            rd_en         <= 1'b1;
            s_axi_arready <= 1'b0;
         end
         if (rd_en) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_data;
            s_axi_rresp  <= rd_ok ? `SCIA_RESP_OKAY : `SCIA_RESP_SLVERR;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule

// File: src/scia_map.vh
// register map and field layout of the indirect fabric access port
// assumes a 12-bit byte address on the register bus and 32-bit data
`ifndef SCIA_MAP_VH
`define SCIA_MAP_VH

// ********************************
// register byte offsets
// ********************************
`define SCIA_AW          12
`define SCIA_OFS_VALUE   12'h1ac
`define SCIA_OFS_CMD     12'h1b0
`define SCIA_OFS_PAUSE   12'h1f0

// ********************************
// command word fields
// ********************************
`define SCIA_BIT_PEND    31
`define SCIA_BIT_DIR     30
`define SCIA_BIT_UP      29
`define SCIA_BIT_DOWN    28
`define SCIA_LANE_HI     19
`define SCIA_LANE_LO     16
`define SCIA_IDX_HI      15
`define SCIA_IDX_LO      0
`define SCIA_PAUSE_HI    15

// ********************************
// reset values and constants
// ********************************
`define SCIA_PAUSE_RST   16'hffff
`define SCIA_WORD_ZERO   32'h0000_0000
`define SCIA_HALF_ZERO   16'h0000
`define SCIA_IDX_ZERO    16'h0000
`define SCIA_IDX_ONE     16'h0001
`define SCIA_RSV_ZERO    8'h00
`define SCIA_LANE_ZERO   4'h0
`define SCIA_LANE_ALL    4'hf
`define SCIA_RESP_OKAY   2'b00
`define SCIA_RESP_SLVERR 2'b10

`endif

// File: src/scia_top.v
// indirect access port to the switch fabric registers, with the upper
// half of the pause-frame source address.
// assumes a fabric register port that holds ack high for one cycle per
// request, and an eeprom loader that strobes its bytes before init_done.
// limitation: a stepping value read with dir_sel clear re-sends value_reg.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ns
`include "scia_map.vh"

module scia_top (
   input  wire                   aclk,
   input  wire                   aresetn,
   input  wire [`SCIA_AW-1:0]    s_axi_awaddr,
   input  wire                   s_axi_awvalid,
   output wire                   s_axi_awready,
   input  wire [31:0]            s_axi_wdata,
   input  wire [3:0]             s_axi_wstrb,
   input  wire                   s_axi_wvalid,
   output wire                   s_axi_wready,
   output wire [1:0]             s_axi_bresp,
   output wire                   s_axi_bvalid,
   input  wire                   s_axi_bready,
   input  wire [`SCIA_AW-1:0]    s_axi_araddr,
   input  wire                   s_axi_arvalid,
   output wire                   s_axi_arready,
   output wire [31:0]            s_axi_rdata,
   output wire [1:0]             s_axi_rresp,
   output wire                   s_axi_rvalid,
   input  wire                   s_axi_rready,
   output reg                    fab_req,
   output reg                    fab_we,
   output reg  [15:0]            fab_addr,
   output reg  [31:0]            fab_wdata,
   output reg  [3:0]             fab_be,
   input  wire                   fab_ack,
   input  wire [31:0]            fab_rdata,
   input  wire                   ee_load,
   input  wire [7:0]             ee_byte_lo,
   input  wire [7:0]             ee_byte_hi,
   input  wire                   init_done,
   output reg  [15:0]            host_station_addr_upper
);

   // ********************************
   // state codes
   // ********************************
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_BUSY = 3'b010;
   localparam [2:0] ST_DONE = 3'b100;

   // ********************************
   // functions
   // ********************************
   // byte-wise merge of bus write data, used with the bus write strobes only
   function [31:0] merge;
      input [31:0] old_word;
      input [31:0] new_word;
      input [3:0]  lanes;
      integer      i;
      begin
         merge = old_word;
         for (i = 0; i < 4; i = i + 1) begin
            if (lanes[i]) begin
               merge[i*8 +: 8] = new_word[i*8 +: 8];
            end
         end
      end
   endfunction

   // next index; up wins over down, and 16-bit width gives the wrap
   function [15:0] step;
      input [15:0] idx;
      input        up;
      input        down;
      begin
         if (up) begin
            step = idx + `SCIA_IDX_ONE;
         end else if (down) begin
            step = idx - `SCIA_IDX_ONE;
         end else begin
            step = idx;
         end
      end
   endfunction

   // map for the write answer only; the read decode lists the same offsets in its own case
   function reg_mapped;
      input [`SCIA_AW-1:0] addr;
      begin
         reg_mapped = (addr == `SCIA_OFS_CMD) ||
                      (addr == `SCIA_OFS_VALUE) ||
                      (addr == `SCIA_OFS_PAUSE);
      end
   endfunction

   // ********************************
   // registers
   // ********************************
   reg  [2:0]            state;
   reg                   op_pending;
   reg                   dir_sel;
   reg                   step_up_en;
   reg                   step_down_en;
   reg  [3:0]            lane_select;
   reg  [15:0]           target_index;
   reg  [31:0]           value_reg;
   reg  [31:0]           fetched;
   reg  [15:0]           pause_addr_upper;
   reg  [31:0]           next_rd_data;
   reg                   next_rd_ok;
   reg                   next_wr_ok;

   wire                  wr_en;
   wire [`SCIA_AW-1:0]   wr_addr;
   wire [31:0]           wr_data;
   wire [3:0]            wr_strb;
   wire                  rd_en;
   wire [`SCIA_AW-1:0]   rd_addr;
   wire [31:0]           cmd_word;
   wire [31:0]           cmd_new;
   wire [31:0]           value_new;
   wire [31:0]           pause_new;
   wire                  wr_cmd;
   wire                  wr_value;
   wire                  wr_pause;
   wire                  rd_value;
   wire                  stepping;
   wire [31:0]           pause_word;
   wire [15:0]           ee_word;
   wire                  launch_cmd;
   wire                  launch_value;
   wire                  launch_read;

   // ********************************
   // bus front end
   // ********************************
   scia_axil_slave u_bus (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .wr_en         (wr_en),
      .wr_addr       (wr_addr),
      .wr_data       (wr_data),
      .wr_strb       (wr_strb),
      .wr_ok         (next_wr_ok),
      .rd_en         (rd_en),
      .rd_addr       (rd_addr),
      .rd_data       (next_rd_data),
      .rd_ok         (next_rd_ok)
   );

   // ********************************
   // decode
   // ********************************
   assign cmd_word  = {op_pending, dir_sel, step_up_en, step_down_en,
                       `SCIA_RSV_ZERO, lane_select,
                       target_index};
   assign cmd_new   = merge(cmd_word, wr_data, wr_strb);
   assign value_new = merge(value_reg, wr_data, wr_strb);
   assign pause_word = {`SCIA_HALF_ZERO, pause_addr_upper};
   assign pause_new = merge(pause_word, wr_data, wr_strb);
   assign ee_word   = {ee_byte_hi, ee_byte_lo};
   assign wr_cmd    = wr_en && (wr_addr == `SCIA_OFS_CMD);
   assign wr_value  = wr_en && (wr_addr == `SCIA_OFS_VALUE);
   assign wr_pause  = wr_en && (wr_addr == `SCIA_OFS_PAUSE);
   assign rd_value  = rd_en && (rd_addr == `SCIA_OFS_VALUE);
   assign stepping  = step_up_en || step_down_en;

   // ********************************
   // access triggers
   // ********************************
   // a stepping value read during a busy access launches nothing
   assign launch_cmd   = wr_cmd && cmd_new[`SCIA_BIT_PEND];
   assign launch_value = wr_value && stepping;
   assign launch_read  = rd_value && stepping && !op_pending;

   always @* begin
      next_wr_ok = reg_mapped(wr_addr);
   end

   // unmapped reads answer zero with slverr
   always @* begin
      next_rd_ok   = 1'b1;
      next_rd_data = `SCIA_WORD_ZERO;
      case (rd_addr)
         `SCIA_OFS_CMD: begin
            next_rd_data = cmd_word;
         end
         `SCIA_OFS_VALUE: begin
            next_rd_data = dir_sel ? fetched : value_reg;
         end
         `SCIA_OFS_PAUSE: begin
            next_rd_data = pause_word;
         end
         default: begin
            next_rd_ok = 1'b0;
         end
      endcase
   end

   // ********************************
   // command, value and fabric sequencer
   // ********************************
   // the sequencer runs first in the block so a host set of op_pending
   // in the same cycle overrides its clear
   always @(posedge aclk) begin
      if (!aresetn) begin
         state        <= ST_IDLE;
         op_pending   <= 1'b0;
         dir_sel      <= 1'b0;
         step_up_en   <= 1'b0;
         step_down_en <= 1'b0;
         lane_select  <= `SCIA_LANE_ZERO;
         target_index <= `SCIA_IDX_ZERO;
         value_reg    <= `SCIA_WORD_ZERO;
         fetched      <= `SCIA_WORD_ZERO;
         fab_req      <= 1'b0;
         fab_we       <= 1'b0;
         fab_addr     <= `SCIA_IDX_ZERO;
         fab_wdata    <= `SCIA_WORD_ZERO;
         fab_be       <= `SCIA_LANE_ZERO;
      end else begin
         case (state)
            ST_IDLE: begin
               if (op_pending) begin
                  fab_req   <= 1'b1;
                  fab_we    <= !dir_sel;
                  fab_addr  <= target_index;
                  fab_wdata <= value_reg;
                  fab_be    <= dir_sel ? `SCIA_LANE_ALL : lane_select;
                  state     <= ST_BUSY;
               end
            end
            ST_BUSY: begin
               if (fab_ack) begin
                  fab_req <= 1'b0;
                  if (!fab_we) begin
                     fetched <= fab_rdata;
                  end
                  state <= ST_DONE;
               end
            end
            ST_DONE: begin
               // fetched is already held here, one cycle before the clear
               op_pending <= 1'b0;
               if (fab_we) begin
                  target_index <= step(target_index, step_up_en,
                                       step_down_en);
               end
               state <= ST_IDLE;
            end
            default: begin
               state   <= ST_IDLE;
               fab_req <= 1'b0;
            end
         endcase

         // host relies on software keeping still while busy
         if (wr_cmd) begin
            dir_sel      <= cmd_new[`SCIA_BIT_DIR];
            step_up_en   <= cmd_new[`SCIA_BIT_UP];
            step_down_en <= cmd_new[`SCIA_BIT_DOWN];
            lane_select  <= cmd_new[`SCIA_LANE_HI:`SCIA_LANE_LO];
            target_index <= cmd_new[`SCIA_IDX_HI:`SCIA_IDX_LO];
            if (launch_cmd) begin
               op_pending <= 1'b1;
            end
         end

         if (wr_value) begin
            value_reg <= value_new;
            if (launch_value) begin
               op_pending <= 1'b1;
            end
         end

         if (launch_read) begin
            target_index <= step(target_index, step_up_en, step_down_en);
            op_pending   <= 1'b1;
         end
      end
   end

   // ********************************
   // pause-frame source address
   // ********************************
   // eeprom preset only before init completes; afterwards the host owns pause_addr_upper, while host_station_addr_upper keeps the eeprom value
   always @(posedge aclk) begin
      if (!aresetn) begin
         pause_addr_upper        <= `SCIA_PAUSE_RST;
         host_station_addr_upper <= `SCIA_PAUSE_RST;
      end else begin
         if (ee_load && !init_done) begin
            pause_addr_upper        <= ee_word;
            host_station_addr_upper <= ee_word;
         end else if (wr_pause && init_done) begin
            pause_addr_upper <= pause_new[`SCIA_PAUSE_HI:0];
         end
      end
   end

endmodule

// File: verif/scia_checker.sv
// checker: fabric port, bus answers and eeprom copy of scia_top
// assumes one clock and a synchronous active low reset; bound below
`timescale 1ns/1ns
`include "scia_map.vh"
module scia_checker (
   input wire                aclk,
   input wire                aresetn,
   input wire [`SCIA_AW-1:0] s_axi_awaddr,
   input wire                s_axi_awvalid,
   input wire                s_axi_awready,
   input wire [31:0]         s_axi_wdata,
   input wire                s_axi_wvalid,
   input wire                s_axi_wready,
   input wire [1:0]          s_axi_bresp,
   input wire                s_axi_bvalid,
   input wire                s_axi_arvalid,
   input wire                s_axi_arready,
   input wire                s_axi_rvalid,
   input wire                fab_req,
   input wire                fab_we,
   input wire [15:0]         fab_addr,
   input wire [31:0]         fab_wdata,
   input wire [3:0]          fab_be,
   input wire                fab_ack,
   input wire                ee_load,
   input wire [7:0]          ee_byte_lo,
   input wire [7:0]          ee_byte_hi,
   input wire                init_done,
   input wire [15:0]         host_station_addr_upper
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ******************
   // assertions
   // ******************
   fab_hold_a: assert property (fab_req && !fab_ack |=> fab_req &&
      $stable({fab_we, fab_addr, fab_wdata, fab_be}))
      else $error("fabric request dropped or changed before ack");
   req_end_a: assert property (fab_req && fab_ack |=> !fab_req)
      else $error("fabric request held after ack");
   rd_lanes_a: assert property (fab_req && !fab_we |-> fab_be == 4'hf)
      else $error("read access without all lanes");
   launch_a: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready && s_axi_wdata[31] &&
      s_axi_awaddr == `SCIA_OFS_CMD |-> ##[1:8] fab_req)
      else $error("pending bit written but no access launched");
   wr_resp_a: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
      else $error("write response late");
   rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=>
      !s_axi_arready ##[0:2] s_axi_rvalid)
      else $error("read answer late or address taken twice");
   ee_copy_a: assert property (ee_load && !init_done |=>
      host_station_addr_upper == {$past(ee_byte_hi), $past(ee_byte_lo)})
      else $error("eeprom bytes not copied");
   ee_late_a: assert property (ee_load && init_done |=>
      $stable(host_station_addr_upper))
      else $error("eeprom load accepted after init");
   cover property (fab_req && fab_ack && fab_we);
   cover property (fab_req && fab_ack && !fab_we);
   cover property (s_axi_bvalid && s_axi_bresp == `SCIA_RESP_SLVERR);
endmodule

bind scia_top scia_checker chk_u (.*);

// File: verif/scia_fabric_model.sv
// fabric register model: acks each request after lat idle cycles
// assumes one request at a time, held until the ack edge
`timescale 1ns/1ns
module scia_fabric_model (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire        fab_req,
   input  wire        fab_we,
   input  wire [15:0] fab_addr,
   input  wire [31:0] fab_wdata,
   input  wire [3:0]  fab_be,
   input  wire [3:0]  lat,
   output reg         fab_ack,
   output reg  [31:0] fab_rdata
);
   reg [31:0] mem [0:65535];
   reg [3:0]  wait_cnt;
   integer    n;
   initial begin
      fab_ack   = 1'b0;
      fab_rdata = 32'h0000_0000;
      for (n = 0; n < 65536; n = n + 1)
         mem[n] = {n[15:0] ^ 16'h5a5a, n[15:0]};
   end
   always @(posedge aclk) begin
      fab_ack   <= 1'b0;
      // released data toggles so a late sample never matches by luck
      fab_rdata <= ~fab_rdata;
      if (!aresetn) begin
         wait_cnt <= 4'h0;
      end else if (fab_req && !fab_ack) begin
         if (wait_cnt >= lat) begin
            wait_cnt  <= 4'h0;
            fab_ack   <= 1'b1;
            fab_rdata <= mem[fab_addr];
            for (n = 0; n < 4; n = n + 1)
               if (fab_we && fab_be[n])
                  mem[fab_addr][8*n +: 8] <= fab_wdata[8*n +: 8];
         end else begin
            wait_cnt <= wait_cnt + 4'h1;
         end
      end
   end
endmodule

// File: verif/scia_top_tb.sv
// testbench: axi4-lite host tasks, fabric model, queued result checks
// assumes dut and model ports match the names declared here
`timescale 1ns/1ns
`include "scia_map.vh"
module scia_top_tb;
   localparam [11:0] a_val = `SCIA_OFS_VALUE;
   localparam [11:0] a_cmd = `SCIA_OFS_CMD;
   localparam [11:0] a_pau = `SCIA_OFS_PAUSE;
   localparam [1:0]  ok = `SCIA_RESP_OKAY;
   localparam [1:0]  err = `SCIA_RESP_SLVERR;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0]  s_axi_wstrb = 4'hf, lat = 4'h0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0, ee_load = 1'b0, init_done = 1'b0;
   logic [7:0]  ee_byte_lo = 8'h00, ee_byte_hi = 8'h00;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, fab_req, fab_we, fab_ack;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata, fab_wdata, fab_rdata, d, m;
   logic [15:0] fab_addr, host_station_addr_upper, i;
   logic [3:0]  fab_be, ln;
   logic        up, dn;
   logic [52:0] fab_seen;
   logic [33:0] q_r[$];
   logic [1:0]  q_b[$];
   logic [52:0] q_f[$];
   logic [31:0] sh[int];
   int          num_errors = 0, num_checks = 0, n_push = 0, n_done = 0, k;
   integer      seed = 56;

   scia_top          dut_u   (.*);
   scia_fabric_model model_u (.*);
   always #25 aclk = ~aclk;
   assign fab_seen = {fab_we, fab_addr, fab_be, fab_we ? fab_wdata : 32'h0};

   // ******************
   // helpers
   // ******************
   function automatic [31:0] fw(input [15:0] a);
      fw = sh.exists(a) ? sh[a] : {a ^ 16'h5a5a, a};
   endfunction
   function automatic [31:0] cw(input p, r, u, w, input [3:0] l,
                                input [15:0] a);
      cw = {p, r, u, w, 8'h00, l, a};
   endfunction
   task automatic chk(input [63:0] seen, input [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input [11:0] a, input [31:0] v, input [1:0] r);
      q_b.push_back(r);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bready && s_axi_bvalid) s_axi_bready <= 1'b0;
      end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
   endtask
   task automatic rd(input [11:0] a, input [1:0] r, input [31:0] e);
      q_r.push_back({r, e});
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rready && s_axi_rvalid) s_axi_rready <= 1'b0;
      end while (s_axi_arvalid || s_axi_rready);
   endtask
   // note one expected fabric access at index i with data d
   task automatic fx(input w, input [3:0] b);
      q_f.push_back({w, i, b, w ? d : 32'h0000_0000});
      n_push++;
   endtask
   // the host may not touch the registers until the access is over
   task automatic wait_op;
      while (n_done != n_push) @(posedge aclk);
      repeat (3) @(posedge aclk);
      lat <= {$random(seed)} % 10;
   endtask
   task automatic wrap_up;
      if (num_errors == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // ******************
   // result monitor
   // ******************
   always @(posedge aclk) begin
      if (s_axi_rvalid && s_axi_rready)
         chk({s_axi_rresp, s_axi_rdata}, q_r.pop_front());
      if (s_axi_bvalid && s_axi_bready)
         chk(s_axi_bresp, q_b.pop_front());
      if (fab_req && fab_ack) begin
         n_done++;
         chk(fab_seen, q_f.pop_front());
      end
   end

   initial begin
      repeat (20000) @(posedge aclk);
      num_errors++;
      wrap_up;
   end

   // ******************
   // scenarios
   // ******************
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk(host_station_addr_upper, 16'hffff);
      rd(a_cmd, ok, 32'h0000_0000);
      rd(a_pau, ok, 32'h0000_ffff);
      rd(a_val, ok, 32'h0000_0000);
      rd(12'h1b4, err, 32'h0000_0000);
      wr(12'h004, 32'h1234_5678, err);
      d = $random(seed);
      {ee_byte_hi, ee_byte_lo} <= d[15:0];
      ee_load <= 1'b1;
      @(posedge aclk);
      ee_load <= 1'b0;
      @(posedge aclk);
      chk(host_station_addr_upper, d[15:0]);
      wr(a_pau, ~d, ok);
      rd(a_pau, ok, {16'h0000, d[15:0]});
      init_done <= 1'b1;
      {ee_byte_hi, ee_byte_lo} <= ~d[15:0];
      ee_load <= 1'b1;
      @(posedge aclk);
      ee_load <= 1'b0;
      @(posedge aclk);
      chk(host_station_addr_upper, d[15:0]);
      wr(a_pau, ~d, ok);
      rd(a_pau, ok, {16'h0000, ~d[15:0]});
      for (k = 0; k < 6; k++) begin
         i = $random(seed);
         d = $random(seed);
         ln = (k == 0) ? 4'h0 : (k == 1) ? 4'hf : 4'($random(seed));
         m = {{8{ln[3]}}, {8{ln[2]}}, {8{ln[1]}}, {8{ln[0]}}};
         wr(a_val, d, ok);
         wr(a_cmd, cw(1, 0, 0, 0, ln, i), ok);
         fx(1'b1, ln);
         rd(a_cmd, ok, cw(1, 0, 0, 0, ln, i));
         sh[i] = (fw(i) & ~m) | (d & m);
         wait_op;
         rd(a_cmd, ok, cw(0, 0, 0, 0, ln, i));
         rd(a_val, ok, d);
         wr(a_cmd, cw(1, 1, 0, 0, ~ln, i), ok);
         fx(1'b0, 4'hf);
         rd(a_cmd, ok, cw(1, 1, 0, 0, ~ln, i));
         wait_op;
         rd(a_val, ok, fw(i));
      end
      for (k = 0; k < 3; k++) begin
         up = (k != 1);
         dn = (k != 0);
         i = up ? 16'hfffe : 16'h0001;
         wr(a_cmd, cw(0, 0, up, dn, 4'hf, i), ok);
         repeat (3) begin
            d = $random(seed);
            wr(a_val, d, ok);
            fx(1'b1, 4'hf);
            rd(a_cmd, ok, cw(1, 0, up, dn, 4'hf, i));
            sh[i] = d;
            wait_op;
            i = up ? i + 16'h0001 : i - 16'h0001;
         end
         rd(a_cmd, ok, cw(0, 0, up, dn, 4'hf, i));
         wr(a_cmd, cw(1, 1, up, dn, 4'hf, i), ok);
         fx(1'b0, 4'hf);
         wait_op;
         repeat (2) begin
            rd(a_val, ok, fw(i));
            i = up ? i + 16'h0001 : i - 16'h0001;
            fx(1'b0, 4'hf);
            rd(a_cmd, ok, cw(1, 1, up, dn, 4'hf, i));
            wait_op;
         end
         wr(a_cmd, cw(0, 1, 0, 0, 4'hf, i), ok);
         rd(a_val, ok, fw(i));
         rd(a_cmd, ok, cw(0, 1, 0, 0, 4'hf, i));
      end
      repeat (8) @(posedge aclk);
      chk(n_push - n_done, 0);
      chk(q_r.size() + q_b.size() + q_f.size(), 0);
      wrap_up;
   end
endmodule
